// ==== scb_pkg.sv ====
// scb_pkg: constants, types and timing for the charge-balance pulse generator.
// assumes: ratio words are signed fixed point with FRAC_W fraction bits,
// and the core clock runs at CLK_FREQ_HZ.
package scb_pkg;

  // ------------------------------------------------------------------
  // number formats
  // ------------------------------------------------------------------
  localparam int RATIO_W = 16;
  localparam int FRAC_W = 14;
  localparam int ACC_W = 19;

  // ------------------------------------------------------------------
  // ratio limits, in units of 2**-FRAC_W of the reference level
  // ------------------------------------------------------------------
  // unbuffered span -0.06 .. 1.06, buffered floor 0.04 (0.10 / 2.5)
  localparam logic signed [RATIO_W-1:0] UNBUF_MIN = 16'hFC29;
  localparam logic signed [RATIO_W-1:0] UNBUF_MAX = 16'h43D7;
  localparam logic signed [RATIO_W-1:0] BUF_MIN = 16'h028F;
  localparam logic signed [RATIO_W-1:0] BUF_MAX = 16'h4000;
  localparam logic signed [RATIO_W-1:0] RATIO_ZERO = 16'h0000;
  localparam logic signed [RATIO_W-1:0] RATIO_ONE = 16'h4000;

  // ------------------------------------------------------------------
  // accumulator: modulus is 10 units, step is 1 + 8 * ratio units
  // ------------------------------------------------------------------
  localparam logic [ACC_W-1:0] ACC_MOD = 19'h28000;
  localparam logic [ACC_W-1:0] STEP_OFFSET = 19'h04000;
  localparam logic [ACC_W-1:0] STEP_FULL = 19'h24000;
  localparam logic [ACC_W-1:0] ACC_RESET = 19'h00000;
  localparam int STEP_SHIFT = 3;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int PD_TIME_US = 1000;
  // longest time, rounded down to whole core cycles
  localparam int PD_CYCLES = PD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam logic [1:0] SETTLE_MCLK = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic {
    MODE_RUN,
    MODE_POWER_DOWN
  } scb_mode_t;

  typedef struct packed {
    logic buffer_select;
    logic signed [RATIO_W-1:0] analog_input_level;
  } scb_sample_t;

endpackage : scb_pkg

// ==== scb_pulse_gen.sv ====
// scb_pulse_gen: synchronous charge-balance pulse generator core.
// assumes: master_clock_input_in is a level synchronous to core_clk_in and
// much slower than it; sample_in is steady around master clock rising edges.

`timescale 1ns/1ps

module scb_pulse_gen #(
  parameter int PD_CYCLES = scb_pkg::PD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic master_clock_input_in,
  input wire scb_pkg::scb_sample_t sample_in,
  output logic frequency_pulse_output_out,
  output logic rate_settling_out,
  output logic power_down_out
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  localparam int PD_CNT_W = $clog2(PD_CYCLES + 1);
  localparam logic [PD_CNT_W-1:0] PD_LAST = PD_CNT_W'(PD_CYCLES - 1);

  // limit the ratio to the selected input range
  function automatic logic signed [scb_pkg::RATIO_W-1:0] clamp_ratio(
    input logic buf_sel,
    input logic signed [scb_pkg::RATIO_W-1:0] r
  );
    logic signed [scb_pkg::RATIO_W-1:0] lo;
    logic signed [scb_pkg::RATIO_W-1:0] hi;
    lo = buf_sel ? scb_pkg::BUF_MIN : scb_pkg::UNBUF_MIN;
    hi = buf_sel ? scb_pkg::BUF_MAX : scb_pkg::UNBUF_MAX;
    if (r < lo) begin
      clamp_ratio = lo;
    end else if (r > hi) begin
      clamp_ratio = hi;
    end else begin
      clamp_ratio = r;
    end
  endfunction : clamp_ratio

  // charge added per master cycle: one unit plus eight times the ratio
  function automatic logic [scb_pkg::ACC_W-1:0] rate_step(
    input logic signed [scb_pkg::RATIO_W-1:0] r
  );
    logic signed [scb_pkg::ACC_W:0] wide;
    wide = (scb_pkg::ACC_W + 1)'(r);
    wide = (wide <<< scb_pkg::STEP_SHIFT) + $signed({1'b0, scb_pkg::STEP_OFFSET});
    rate_step = wide[scb_pkg::ACC_W-1:0];
  endfunction : rate_step

  // ------------------------------------------------------------------
  // master clock edges
  // ------------------------------------------------------------------
  logic mclk_d_r;
  logic mclk_rise;
  logic mclk_fall;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mclk_d_r <= 1'b0;
    end else begin
      mclk_d_r <= master_clock_input_in;
    end
  end

  assign mclk_rise = master_clock_input_in & ~mclk_d_r;
  assign mclk_fall = ~master_clock_input_in & mclk_d_r;

  // ------------------------------------------------------------------
  // power-down detection
  // ------------------------------------------------------------------
  scb_pkg::scb_mode_t mode_r;
  logic [PD_CNT_W-1:0] low_cnt_r;
  logic pd_hit;

  assign pd_hit = !master_clock_input_in && (low_cnt_r == PD_LAST);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      low_cnt_r <= '0;
    end else if (master_clock_input_in) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != PD_LAST) begin
      low_cnt_r <= low_cnt_r + PD_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_r <= scb_pkg::MODE_RUN;
    end else begin
      unique case (mode_r)
        scb_pkg::MODE_RUN: begin
          if (pd_hit) begin
            mode_r <= scb_pkg::MODE_POWER_DOWN;
          end
        end
        scb_pkg::MODE_POWER_DOWN: begin
          if (mclk_rise) begin
            mode_r <= scb_pkg::MODE_RUN;
          end
        end
      endcase
    end
  end

  logic run;
  assign run = (mode_r == scb_pkg::MODE_RUN);

  // ------------------------------------------------------------------
  // input sampling and settling
  // ------------------------------------------------------------------
  logic signed [scb_pkg::RATIO_W-1:0] ratio_r;
  logic signed [scb_pkg::RATIO_W-1:0] ratio_nxt;
  logic buf_sel_r;
  logic [1:0] settle_r;
  logic input_step;

  assign ratio_nxt = clamp_ratio(sample_in.buffer_select, sample_in.analog_input_level);
  assign input_step = (ratio_nxt != ratio_r);

  // one sample per master cycle, taken on its rising edge
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ratio_r <= scb_pkg::RATIO_ZERO;
      buf_sel_r <= 1'b0;
    end else if (mclk_rise) begin
      ratio_r <= ratio_nxt;
      buf_sel_r <= sample_in.buffer_select;
    end
  end

  // counts the master cycles until the rate reflects a new input
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      settle_r <= scb_pkg::SETTLE_MCLK;
    end else if (mclk_rise) begin
      if (input_step || !run) begin
        settle_r <= scb_pkg::SETTLE_MCLK;
      end else if (settle_r != 2'h0) begin
        settle_r <= settle_r - 2'h1;
      end
    end
  end

  assign rate_settling_out = (settle_r != 2'h0);

  // ------------------------------------------------------------------
  // charge-balance loop
  // ------------------------------------------------------------------
  logic [scb_pkg::ACC_W-1:0] acc_r;
  logic [scb_pkg::ACC_W-1:0] step;
  logic [scb_pkg::ACC_W:0] acc_sum;
  logic overflow;

  assign step = rate_step(ratio_r);
  assign acc_sum = {1'b0, acc_r} + {1'b0, step};
  // comparator decision of the loop
  assign overflow = (acc_sum >= {1'b0, scb_pkg::ACC_MOD});

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      acc_r <= scb_pkg::ACC_RESET;
    end else if (!run || pd_hit) begin
      // cleared on the power-down edge itself, so no stale charge survives
      acc_r <= scb_pkg::ACC_RESET;
    end else if (mclk_rise) begin
      if (overflow) begin
        // one-bit feedback removes one reference charge
        acc_r <= scb_pkg::ACC_W'(acc_sum - {1'b0, scb_pkg::ACC_MOD});
      end else begin
        acc_r <= acc_sum[scb_pkg::ACC_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // output pulse
  // ------------------------------------------------------------------
  logic freq_pulse_r;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      freq_pulse_r <= 1'b0;
    end else if (!run || pd_hit) begin
      freq_pulse_r <= 1'b1;
    end else if (mclk_rise) begin
      freq_pulse_r <= overflow;
    end else if (mclk_fall) begin
      freq_pulse_r <= 1'b0;
    end
  end

  assign frequency_pulse_output_out = freq_pulse_r;
  assign power_down_out = ~run;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_pulse_on_overflow;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && mclk_rise && overflow && !pd_hit) |=> frequency_pulse_output_out;
  endproperty
  a_pulse_on_overflow: assert property (p_pulse_on_overflow)
    else $error("no pulse after accumulator overflow");

  property p_no_pulse_without_overflow;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && mclk_rise && !overflow && !pd_hit) |=> !frequency_pulse_output_out;
  endproperty
  a_no_pulse_without_overflow: assert property (p_no_pulse_without_overflow)
    else $error("pulse without accumulator overflow");

  property p_width_high_phase;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && $past(run) && !mclk_d_r) |-> !frequency_pulse_output_out;
  endproperty
  a_width_high_phase: assert property (p_width_high_phase)
    else $error("pulse outlives master clock high phase");

  property p_pulse_holds_high_phase;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && frequency_pulse_output_out && master_clock_input_in && mclk_d_r)
        |=> frequency_pulse_output_out;
  endproperty
  a_pulse_holds_high_phase: assert property (p_pulse_holds_high_phase)
    else $error("pulse ends before master clock falls");

  property p_rise_aligned;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && $past(run) && $rose(frequency_pulse_output_out)) |-> $past(mclk_rise);
  endproperty
  a_rise_aligned: assert property (p_rise_aligned)
    else $error("pulse not launched by a master clock rising edge");

  property p_power_down_entry;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && pd_hit) |=> (!run && frequency_pulse_output_out) [*2];
  endproperty
  a_power_down_entry: assert property (p_power_down_entry)
    else $error("power-down not entered or output not high");

  property p_power_down_high;
    @(posedge core_clk_in) disable iff (!resetn_in)
      !run |-> frequency_pulse_output_out && (acc_r == scb_pkg::ACC_RESET);
  endproperty
  a_power_down_high: assert property (p_power_down_high)
    else $error("output low or loop active during power-down");

  property p_settle_flag_set;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (mclk_rise && input_step) |=> (settle_r == scb_pkg::SETTLE_MCLK);
  endproperty
  a_settle_flag_set: assert property (p_settle_flag_set)
    else $error("settling not flagged after an input step");

  property p_buffered_floor;
    @(posedge core_clk_in) disable iff (!resetn_in)
      buf_sel_r |-> (ratio_r >= scb_pkg::BUF_MIN) && (ratio_r <= scb_pkg::BUF_MAX);
  endproperty
  a_buffered_floor: assert property (p_buffered_floor)
    else $error("buffered ratio outside its range");

  property p_unbuffered_range;
    @(posedge core_clk_in) disable iff (!resetn_in)
      !buf_sel_r |-> (ratio_r >= scb_pkg::UNBUF_MIN) && (ratio_r <= scb_pkg::UNBUF_MAX);
  endproperty
  a_unbuffered_range: assert property (p_unbuffered_range)
    else $error("unbuffered ratio outside its range");

  property p_full_scale_step;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ratio_r == scb_pkg::RATIO_ONE) |-> (step == scb_pkg::STEP_FULL);
  endproperty
  a_full_scale_step: assert property (p_full_scale_step)
    else $error("full-scale step is not nine tenths of the modulus");

  property p_acc_balanced;
    @(posedge core_clk_in) disable iff (!resetn_in)
      acc_r < scb_pkg::ACC_MOD;
  endproperty
  a_acc_balanced: assert property (p_acc_balanced)
    else $error("integrated charge left its bounds");

  property p_sample_once;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (run && !mclk_rise && !pd_hit) |=> $stable(acc_r) && $stable(ratio_r);
  endproperty
  a_sample_once: assert property (p_sample_once)
    else $error("loop advanced without a master clock rising edge");

  c_pulse: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    run && $rose(frequency_pulse_output_out));
  c_back_to_back: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    run && mclk_rise && overflow ##[2:20] (mclk_rise && overflow));
  c_power_down: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    run && pd_hit);
  c_buffered_floor: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
    buf_sel_r && (ratio_r == scb_pkg::BUF_MIN));

endmodule : scb_pulse_gen

// ==== scb_pulse_counter.sv ====
// scb_pulse_counter: receiving pulse counter at the far side of the pulse output.
// assumes: the pulse train is synchronous to core_clk_in; gate comes from the bench.
`timescale 1ns/1ps

module scb_pulse_counter (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic pulse_in,
  input wire logic gate_in,
  input wire logic settling_in,
  output logic [31:0] count_out
);
  logic pulse_d_r;

  // ------------------------------------------------------------------
  // rising-edge counter
  // ------------------------------------------------------------------
  // starts as if high, so a line held high is never taken for a pulse
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pulse_d_r <= 1'b1;
      count_out <= 32'h0000_0000;
    end else begin
      pulse_d_r <= pulse_in;
      // pulses while the rate settles are ignored
      if (pulse_in && !pulse_d_r && gate_in && !settling_in) begin
        count_out <= count_out + 32'h0000_0001;
      end
    end
  end
endmodule : scb_pulse_counter

// ==== sync_charge_balance_pulse_gen_tb.sv ====
// sync_charge_balance_pulse_gen_tb: self-checking bench for the pulse generator.
// assumes: the bench makes the master clock level and drives inputs on falling edges.
`timescale 1ns/1ps

module sync_charge_balance_pulse_gen_tb;
  localparam int PD_SIM = 40;
  localparam int N_PER = 500;
  logic clk;
  logic resetn;
  logic mclk;
  logic gate;
  scb_pkg::scb_sample_t smp;
  logic freq_pulse;
  logic settling;
  logic pd;
  logic [31:0] cnt;
  int n_fail;
  int compares;

  scb_pulse_gen #(.PD_CYCLES(PD_SIM)) dut_u (
    .core_clk_in(clk),
    .resetn_in(resetn),
    .master_clock_input_in(mclk),
    .sample_in(smp),
    .frequency_pulse_output_out(freq_pulse),
    .rate_settling_out(settling),
    .power_down_out(pd)
  );

  scb_pulse_counter rx_u (
    .core_clk_in(clk),
    .resetn_in(resetn),
    .pulse_in(freq_pulse),
    .gate_in(gate),
    .settling_in(settling),
    .count_out(cnt)
  );

  // ------------------------------------------------------------------
  // clock, watchdog, common tasks
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // one master period, entered at a falling edge; checks pulse shape when chk is set
  task automatic mclk_period(input int hi, input int lo, input bit chk, output logic p);
    logic s;
    mclk = 1'b1;
    p = 1'b0;
    for (int k = 1; k <= hi + lo; k++) begin
      @(negedge clk);
      s = freq_pulse;
      if (k == 1) begin
        p = s;
      end else if (chk && k <= hi) begin
        check(s, p, "pulse width");
      end else if (chk) begin
        check(s, 1'b0, "pulse after master fall");
      end
      if (k == hi) mclk = 1'b0;
    end
  endtask : mclk_period

  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(negedge clk);
    check(freq_pulse, 1'b0, "output in reset");
    check(settling, 1'b1, "settling in reset");
    check(pd, 1'b0, "power-down in reset");
    resetn = 1'b1;
  endtask : do_reset

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // step to a new input, wait out settling, then count pulses over N_PER periods
  task automatic run_rate(input logic bsel, input logic [15:0] lvl, input int per_mille,
                          input int smin, input int smax);
    logic p;
    int gap;
    bit seen;
    int got;
    int exp;
    smp.buffer_select = bsel;
    smp.analog_input_level = lvl;
    mclk_period(2, 3, 1'b1, p);
    check(settling, 1'b1, "settling after step");
    for (int i = 0; i < 3; i++) mclk_period(2, 3, 1'b1, p);
    check(settling, 1'b0, "settled");
    gate = 1'b1;
    got = int'(cnt);
    gap = 0;
    seen = 1'b0;
    for (int i = 0; i < N_PER; i++) begin
      mclk_period(2, 3, 1'b1, p);
      gap++;
      if (p === 1'b1) begin
        if (seen && smin != 0) begin
          check(gap >= smin && gap <= smax, 1'b1, "pulse spacing");
        end
        gap = 0;
        seen = 1'b1;
      end
    end
    gate = 1'b0;
    @(negedge clk);
    got = int'(cnt) - got;
    exp = per_mille * N_PER / 1000;
    check(got >= exp - 1 && got <= exp + 1, 1'b1, "mean pulse rate");
  endtask : run_rate

  task automatic run_power_down();
    logic p;
    repeat (PD_SIM - 6) @(negedge clk);
    check(pd, 1'b0, "power-down too early");
    repeat (12) @(negedge clk);
    check(pd, 1'b1, "power-down entered");
    check(freq_pulse, 1'b1, "output high in power-down");
    repeat (20) @(negedge clk);
    check(freq_pulse, 1'b1, "no pulses in power-down");
    for (int i = 0; i < 3; i++) mclk_period(2, 2, 1'b0, p);
    check(pd, 1'b0, "power-down left on master rise");
  endtask : run_power_down

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    resetn = 1'b0;
    mclk = 1'b0;
    gate = 1'b0;
    smp = '0;
    repeat (20) @(negedge clk);
    do_reset(1);
    run_rate(1'b0, 16'h0000, 100, 10, 10);
    run_rate(1'b0, 16'h4000, 900, 1, 2);
    run_rate(1'b0, 16'h1000, 300, 3, 4);
    run_rate(1'b0, 16'h8000, 52, 0, 0);
    run_rate(1'b0, 16'h7FFF, 948, 0, 0);
    run_rate(1'b1, 16'h0000, 132, 0, 0);
    run_rate(1'b1, 16'h7FFF, 900, 1, 2);
    run_power_down();
    run_rate(1'b1, 16'h2000, 500, 2, 2);
    do_reset(3);
    run_rate(1'b0, 16'h0800, 200, 5, 5);
    give_verdict();
  end
endmodule : sync_charge_balance_pulse_gen_tb
